// ---- design/sleep_mask_cfg.svh ----
// Offsets, field positions, reset values and event slots of the mask bank
`ifndef SLEEP_MASK_CFG_SVH
`define SLEEP_MASK_CFG_SVH

// Register offsets
`define OFS_SYSTEM_SLEEP_STATE      8'he4
`define OFS_SLEEP1_INPUT_MASK       8'he5
`define OFS_SLEEP1_FAN_MASK         8'he6
`define OFS_SLEEP3_INPUT_MASK       8'he7
`define OFS_SLEEP3_FAN_MASK         8'he8
`define OFS_SLEEP3_VOLT_TEMP_MASK   8'he9
`define OFS_SLEEP45_INPUT_MASK      8'hea
`define OFS_SLEEP45_VOLT_TEMP_MASK  8'heb
`define OFS_INPUT_ERROR_MASK        8'hec
`define OFS_ASSORTED_ERROR_MASK     8'hed
`define OFS_ZONE1_TEMP_OFFSET       8'hee
`define OFS_ZONE2_TEMP_OFFSET       8'hef

// Reset values
`define RST_SLEEP_STATE             2'h3
`define RST_INPUT_MASK              8'hff
`define RST_FAN_MASK                4'hf
`define RST_VOLT_TEMP_MASK          4'h7
`define RST_ASSORTED_MASK           6'h3f
`define RST_ZONE_OFFSET             6'h00

// Field positions
`define FLD_VT_TEMP_BIT             3
`define FLD_ASSORTED_VRD_LSB        0
`define FLD_ASSORTED_TERM_LSB       2
`define FLD_ASSORTED_DVCC_LSB       4

// Slots in the error event vector
`define EV_GPI_LSB                  0
`define EV_FAN_LSB                  8
`define EV_ANALOG_LSB               12
`define EV_ZTEMP_LSB                15
`define EV_ZDIODE_LSB               17
`define EV_VRD_LSB                  19
`define EV_TERM_LSB                 21
`define EV_DVCC_LSB                 23
`define EV_COUNT                    25

// Zone temperature width and offset width
`define TEMP_WIDTH                  8
`define OFFSET_WIDTH                6

`endif

// ---- design/sleep_mask_pkg.sv ----
// Types shared by the sleep-state error mask bank
`include "sleep_mask_cfg.svh"

package sleep_mask_pkg;

    typedef enum logic [1:0] {
        SLEEP_WORKING,
        SLEEP_S1,
        SLEEP_S3,
        SLEEP_S45
    } sleep_state_t;

    typedef logic [`EV_COUNT-1:0] error_vec_t;

    typedef struct packed {
        sleep_state_t                sleep_state_field;
        logic [7:0]                  sleep1_input;
        logic [3:0]                  sleep1_fan;
        logic [7:0]                  sleep3_input;
        logic [3:0]                  sleep3_fan;
        logic [3:0]                  sleep3_volt_temp;
        logic [7:0]                  sleep45_input;
        logic [3:0]                  sleep45_volt_temp;
        logic [7:0]                  input_error;
        logic [5:0]                  assorted;
        logic [`OFFSET_WIDTH-1:0]    zone1_offset_field;
        logic [`OFFSET_WIDTH-1:0]    zone2_offset_field;
        logic [7:0]                  rdata;
        logic                        rvalid;
        error_vec_t                  error_event;
        logic [7:0]                  input_level;
    } mask_state_t;

    typedef struct packed {
        logic [`TEMP_WIDTH-1:0]      temp;
        logic                        valid;
    } adjust_state_t;

endpackage : sleep_mask_pkg

// ---- design/temp_adjust_if.sv ----
// Raw and adjusted zone temperature between the bank and its offset adder
`timescale 1ns/1ns
`default_nettype none
`include "sleep_mask_cfg.svh"

interface temp_adjust_if;
    logic [`TEMP_WIDTH-1:0]   raw;
    logic                     raw_valid;
    logic [`OFFSET_WIDTH-1:0] offset;
    logic [`TEMP_WIDTH-1:0]   adjusted;
    logic                     adjusted_valid;

    modport feed  (output raw, output raw_valid, output offset, input adjusted, input adjusted_valid);
    modport adder (input raw, input raw_valid, input offset, output adjusted, output adjusted_valid);
endinterface : temp_adjust_if

`default_nettype wire

// ---- design/zone_temp_adjust.sv ----
// Adds a signed zone offset to each temperature measurement, saturating
`timescale 1ns/1ns
`default_nettype none
`include "sleep_mask_cfg.svh"

module zone_temp_adjust (
    input  wire logic         clk_sys_i,
    input  wire logic         sys_rst_i,
    temp_adjust_if.adder      link
);

    localparam int SUM_W = `TEMP_WIDTH + 1;
    localparam logic signed [SUM_W-1:0] TEMP_MAX = SUM_W'(signed'(2 ** (`TEMP_WIDTH - 1) - 1));
    localparam logic signed [SUM_W-1:0] TEMP_MIN = -SUM_W'(signed'(2 ** (`TEMP_WIDTH - 1)));

    sleep_mask_pkg::adjust_state_t q, d;
    logic signed [SUM_W-1:0] sum;

    // -------------------------------------------------------------
    // Offset addition
    // -------------------------------------------------------------
    always_comb
    begin
        sum = SUM_W'(signed'(link.raw)) + SUM_W'(signed'(link.offset));
        d = q;
        d.valid = link.raw_valid;
        if (link.raw_valid)
        begin
            // Saturate so a large offset cannot wrap hot into cold
            if (sum > TEMP_MAX)
                d.temp = TEMP_MAX[`TEMP_WIDTH-1:0];
            else if (sum < TEMP_MIN)
                d.temp = TEMP_MIN[`TEMP_WIDTH-1:0];
            else
                d.temp = sum[`TEMP_WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            q <= '0;
        else
            q <= d;
    end

    assign link.adjusted       = q.temp;
    assign link.adjusted_valid = q.valid;

endmodule : zone_temp_adjust

`default_nettype wire

// ---- design/sleep_state_error_masking.sv ----
// Sleep-state and sleep-independent error masking with zone temperature offsets
//
// Functional notes
// RQ1 - Sleep field 00 working, 01 S1, 10 S3, 11 S4/5
// RQ2 - Host keeps sleep field equal to system state
// RQ3 - Sleep states mask by own registers plus standard set
// RQ4 - Reset forces sleep field to S4/5
// RQ5 - S1 input mask bits suppress inputs 0-7
// RQ6 - S1 fan mask suppresses fans 1-4, resets 0Fh
// RQ7 - S3 input mask bits suppress inputs 0-7
// RQ8 - S3 fan mask suppresses fans 1-4, upper reserved
// RQ9 - S3 volt mask bits 0-2 suppress analog 12-14
// RQ10 - S3 volt bit 3 suppresses zone temp, diode faults
// RQ11 - S4/5 input mask bits suppress inputs 0-7
// RQ12 - S4/5 volt mask: analog 12-14, zone temp/diode
// RQ13 - Input error mask suppresses inputs in every state
// RQ14 - Input mask spares live input state
// RQ15 - Assorted mask: regulator hot and termination events
// RQ16 - Assorted bits 4-5 suppress dynamic core voltage
// RQ17 - Zone 1 signed offset added to each measurement
// RQ18 - Offset +31 to -32; adjusted value used everywhere
// RQ19 - Zone 2 offset likewise; both reset zero
// RQ20 - Global mask bit suppresses all error events
// RQ21 - Any applicable mask set means event suppressed
`timescale 1ns/1ns
`default_nettype none
`include "sleep_mask_cfg.svh"

module sleep_state_error_masking #(
    parameter logic [`EV_COUNT-1:0] STD_SLEEP1_MASK  = '0,
    parameter logic [`EV_COUNT-1:0] STD_SLEEP3_MASK  = '0,
    parameter logic [`EV_COUNT-1:0] STD_SLEEP45_MASK = '0,
    parameter int                   NUM_ZONES        = 2
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   sys_rst_i,
    // Register access
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_write_i,
    input  wire logic                   reg_read_i,
    output logic      [7:0]             reg_rdata_o,
    output logic                        reg_rvalid_o,
    // Global mask from the configuration register
    input  wire logic                   global_error_mask_bit_i,
    // Raw error events
    input  wire logic [7:0]             input_error_i,
    input  wire logic [3:0]             fan_error_i,
    input  wire logic [2:0]             analog_error_i,
    input  wire logic [1:0]             zone_temp_error_i,
    input  wire logic [1:0]             zone_diode_error_i,
    input  wire logic [1:0]             regulator_hot_input_i,
    input  wire logic [1:0]             termination_sense_input_i,
    input  wire logic [1:0]             core_volt_dynamic_error_i,
    // Live input levels
    input  wire logic [7:0]             input_level_i,
    output logic      [7:0]             input_level_o,
    // Events that reach the status registers
    output logic      [`EV_COUNT-1:0]   error_event_o,
    output logic      [1:0]             sleep_state_field_o,
    // Zone temperatures
    input  wire logic [`TEMP_WIDTH-1:0] zone1_temp_raw_i,
    input  wire logic                   zone1_temp_raw_valid_i,
    input  wire logic [`TEMP_WIDTH-1:0] zone2_temp_raw_i,
    input  wire logic                   zone2_temp_raw_valid_i,
    output logic      [`TEMP_WIDTH-1:0] zone1_temp_o,
    output logic                        zone1_temp_valid_o,
    output logic      [`TEMP_WIDTH-1:0] zone2_temp_o,
    output logic                        zone2_temp_valid_o
);

    // -------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------
    if (NUM_ZONES != 2)
    begin : g_bad_zones
        $error("Only two adjustable zones are supported");
    end

    if (`TEMP_WIDTH < `OFFSET_WIDTH + 1)
    begin : g_bad_width
        $error("Temperature narrower than offset range");
    end

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    sleep_mask_pkg::mask_state_t q, d;
    sleep_mask_pkg::error_vec_t  raw_events;
    sleep_mask_pkg::error_vec_t  sleep_mask;
    sleep_mask_pkg::error_vec_t  fixed_mask;
    sleep_mask_pkg::error_vec_t  suppress;
    logic [7:0]                  rd_mux;

    temp_adjust_if zone_link [NUM_ZONES] ();

    assign raw_events = {core_volt_dynamic_error_i,
                         termination_sense_input_i,
                         regulator_hot_input_i,
                         zone_diode_error_i,
                         zone_temp_error_i,
                         analog_error_i,
                         fan_error_i,
                         input_error_i};

    // -------------------------------------------------------------
    // Mask selection
    // -------------------------------------------------------------
    always_comb
    begin
        sleep_mask = '0;
        unique case (q.sleep_state_field)                                         // [RQ1] [RQ3]
            sleep_mask_pkg::SLEEP_WORKING:
            begin
                sleep_mask = '0;
            end
            sleep_mask_pkg::SLEEP_S1:
            begin
                sleep_mask = STD_SLEEP1_MASK;
                sleep_mask[`EV_GPI_LSB +: 8] |= q.sleep1_input; // [RQ5]
                sleep_mask[`EV_FAN_LSB +: 4] |= q.sleep1_fan; // [RQ6]
            end
            sleep_mask_pkg::SLEEP_S3:
            begin
                sleep_mask = STD_SLEEP3_MASK;
                sleep_mask[`EV_GPI_LSB +: 8] |= q.sleep3_input; // [RQ7]
                sleep_mask[`EV_FAN_LSB +: 4] |= q.sleep3_fan; // [RQ8]
                sleep_mask[`EV_ANALOG_LSB +: 3]
                    |= q.sleep3_volt_temp[2:0]; // [RQ9]
                sleep_mask[`EV_ZTEMP_LSB +: 2]
                    |= {2{q.sleep3_volt_temp[`FLD_VT_TEMP_BIT]}}; // [RQ10]
                sleep_mask[`EV_ZDIODE_LSB +: 2]
                    |= {2{q.sleep3_volt_temp[`FLD_VT_TEMP_BIT]}}; // [RQ10]
            end
            sleep_mask_pkg::SLEEP_S45:
            begin
                sleep_mask = STD_SLEEP45_MASK;
                sleep_mask[`EV_GPI_LSB +: 8] |= q.sleep45_input; // [RQ11]
                sleep_mask[`EV_ANALOG_LSB +: 3]
                    |= q.sleep45_volt_temp[2:0]; // [RQ12]
                sleep_mask[`EV_ZTEMP_LSB +: 2]
                    |= {2{q.sleep45_volt_temp[`FLD_VT_TEMP_BIT]}}; // [RQ12]
                sleep_mask[`EV_ZDIODE_LSB +: 2]
                    |= {2{q.sleep45_volt_temp[`FLD_VT_TEMP_BIT]}}; // [RQ12]
            end
        endcase
    end

    always_comb
    begin
        fixed_mask = '0;
        fixed_mask[`EV_GPI_LSB +: 8]  = q.input_error;                              // [RQ13]
        fixed_mask[`EV_VRD_LSB +: 2]  = q.assorted[`FLD_ASSORTED_VRD_LSB +: 2];     // [RQ15]
        fixed_mask[`EV_TERM_LSB +: 2] = q.assorted[`FLD_ASSORTED_TERM_LSB +: 2];    // [RQ15]
        fixed_mask[`EV_DVCC_LSB +: 2] = q.assorted[`FLD_ASSORTED_DVCC_LSB +: 2];    // [RQ16]
    end

    // Global mask leaves every mask register untouched
    assign suppress = {`EV_COUNT{global_error_mask_bit_i}}                         // [RQ20]
                    | fixed_mask | sleep_mask;                                      // [RQ21]

    // -------------------------------------------------------------
    // Read mux
    // -------------------------------------------------------------
    always_comb
    begin
        rd_mux = 8'h00;
        unique case (reg_addr_i)
            `OFS_SYSTEM_SLEEP_STATE:     rd_mux = {6'h00, q.sleep_state_field};
            `OFS_SLEEP1_INPUT_MASK:      rd_mux = q.sleep1_input;
            `OFS_SLEEP1_FAN_MASK:        rd_mux = {4'h0, q.sleep1_fan};
            `OFS_SLEEP3_INPUT_MASK:      rd_mux = q.sleep3_input;
            `OFS_SLEEP3_FAN_MASK:        rd_mux = {4'h0, q.sleep3_fan};
            `OFS_SLEEP3_VOLT_TEMP_MASK:  rd_mux = {4'h0, q.sleep3_volt_temp};
            `OFS_SLEEP45_INPUT_MASK:     rd_mux = q.sleep45_input;
            `OFS_SLEEP45_VOLT_TEMP_MASK: rd_mux = {4'h0, q.sleep45_volt_temp};
            `OFS_INPUT_ERROR_MASK:       rd_mux = q.input_error;
            `OFS_ASSORTED_ERROR_MASK:    rd_mux = {2'h0, q.assorted};
            `OFS_ZONE1_TEMP_OFFSET:      rd_mux = {2'h0, q.zone1_offset_field};
            `OFS_ZONE2_TEMP_OFFSET:      rd_mux = {2'h0, q.zone2_offset_field};
            default:                     rd_mux = 8'h00;
        endcase
    end

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.rvalid = reg_read_i;
        if (reg_read_i)
            d.rdata = rd_mux;
        // Reserved bits are dropped on write so they always read zero
        if (reg_write_i)
        begin
            unique case (reg_addr_i)
                `OFS_SYSTEM_SLEEP_STATE:
                    d.sleep_state_field = sleep_mask_pkg::sleep_state_t'(reg_wdata_i[1:0]);  // [RQ1]
                `OFS_SLEEP1_INPUT_MASK:      d.sleep1_input       = reg_wdata_i;
                `OFS_SLEEP1_FAN_MASK:        d.sleep1_fan         = reg_wdata_i[3:0];                // [RQ6]
                `OFS_SLEEP3_INPUT_MASK:      d.sleep3_input       = reg_wdata_i;
                `OFS_SLEEP3_FAN_MASK:        d.sleep3_fan         = reg_wdata_i[3:0];                // [RQ8]
                `OFS_SLEEP3_VOLT_TEMP_MASK:  d.sleep3_volt_temp   = reg_wdata_i[3:0];
                `OFS_SLEEP45_INPUT_MASK:     d.sleep45_input      = reg_wdata_i;
                `OFS_SLEEP45_VOLT_TEMP_MASK: d.sleep45_volt_temp  = reg_wdata_i[3:0];
                `OFS_INPUT_ERROR_MASK:       d.input_error        = reg_wdata_i;
                `OFS_ASSORTED_ERROR_MASK:    d.assorted           = reg_wdata_i[5:0];                // [RQ16]
                `OFS_ZONE1_TEMP_OFFSET:      d.zone1_offset_field = reg_wdata_i[`OFFSET_WIDTH-1:0];  // [RQ17]
                `OFS_ZONE2_TEMP_OFFSET:      d.zone2_offset_field = reg_wdata_i[`OFFSET_WIDTH-1:0];  // [RQ19]
                default:                     d = d;
            endcase
        end
        // Suppressed events never reach the status logic
        d.error_event = raw_events & ~suppress;                                     // [RQ21]
        // Live levels pass untouched by any mask
        d.input_level = input_level_i;                                              // [RQ14]
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            q                    <= '0;
            q.sleep_state_field  <= sleep_mask_pkg::sleep_state_t'(`RST_SLEEP_STATE); // [RQ4]
            q.sleep1_input       <= `RST_INPUT_MASK; // [RQ5]
            q.sleep1_fan         <= `RST_FAN_MASK; // [RQ6]
            q.sleep3_input       <= `RST_INPUT_MASK; // [RQ7]
            q.sleep3_fan         <= `RST_FAN_MASK;
            q.sleep3_volt_temp   <= `RST_VOLT_TEMP_MASK; // [RQ9]
            q.sleep45_input      <= `RST_INPUT_MASK; // [RQ11]
            q.sleep45_volt_temp  <= `RST_VOLT_TEMP_MASK; // [RQ12]
            q.input_error        <= `RST_INPUT_MASK; // [RQ13]
            q.assorted           <= `RST_ASSORTED_MASK; // [RQ15]
            q.zone1_offset_field <= `RST_ZONE_OFFSET;
            q.zone2_offset_field <= `RST_ZONE_OFFSET; // [RQ19]
        end
        else
        begin
            q <= d;
        end
    end

    // -------------------------------------------------------------
    // Zone offset adders
    // -------------------------------------------------------------
    // Adjusted value is the only temperature handed onward
    assign zone_link[0].raw       = zone1_temp_raw_i;
    assign zone_link[0].raw_valid = zone1_temp_raw_valid_i;
    assign zone_link[0].offset    = q.zone1_offset_field;                           // [RQ17]
    assign zone_link[1].raw       = zone2_temp_raw_i;
    assign zone_link[1].raw_valid = zone2_temp_raw_valid_i;
    assign zone_link[1].offset    = q.zone2_offset_field;                           // [RQ19]

    for (genvar z = 0; z < NUM_ZONES; z++)
    begin : g_zone
        zone_temp_adjust u_adjust (
            .clk_sys_i (clk_sys_i),
            .sys_rst_i (sys_rst_i),
            .link      (zone_link[z])                                               // [RQ18]
        );
    end

    assign zone1_temp_o       = zone_link[0].adjusted;
    assign zone1_temp_valid_o = zone_link[0].adjusted_valid;
    assign zone2_temp_o       = zone_link[1].adjusted;
    assign zone2_temp_valid_o = zone_link[1].adjusted_valid;

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign reg_rdata_o         = q.rdata;
    assign reg_rvalid_o        = q.rvalid;
    assign error_event_o       = q.error_event;
    assign input_level_o       = q.input_level;
    assign sleep_state_field_o = q.sleep_state_field;

endmodule : sleep_state_error_masking

`default_nettype wire

// ---- tb/sleep_mask_props.sv ----
// Port-level assertions for the sleep-state error mask bank
`timescale 1ns/1ns
`default_nettype none
`include "sleep_mask_cfg.svh"
module sleep_mask_props (
    input wire logic                 clk_sys_i,
    input wire logic                 sys_rst_i,
    input wire logic [7:0]           reg_addr_i,
    input wire logic [7:0]           reg_wdata_i,
    input wire logic                 reg_write_i,
    input wire logic                 global_error_mask_bit_i,
    input wire logic [7:0]           input_error_i,
    input wire logic [3:0]           fan_error_i,
    input wire logic [7:0]           input_level_i,
    input wire logic [7:0]           input_level_o,
    input wire logic [`EV_COUNT-1:0] error_event_o,
    input wire logic [1:0]           sleep_state_field_o,
    input wire logic                 zone1_temp_raw_valid_i,
    input wire logic                 zone1_temp_valid_o,
    input wire logic                 zone2_temp_raw_valid_i,
    input wire logic                 zone2_temp_valid_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // ------
    // Checks
    // ------
    property p_rst_s45; disable iff (1'b0) sys_rst_i |=> sleep_state_field_o == 2'h3; endproperty
    a_rst_s45: assert property (p_rst_s45) else $error("sleep field not S4/5 after reset");
    property p_sleep_wr; reg_write_i && reg_addr_i == 8'he4 |=> {6'h00, sleep_state_field_o} == ($past(reg_wdata_i) & 8'h03); endproperty
    a_sleep_wr: assert property (p_sleep_wr) else $error("sleep field write lost");
    property p_sleep_hold; !(reg_write_i && reg_addr_i == 8'he4) |=> $stable(sleep_state_field_o); endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep field changed unasked");
    property p_gmask; global_error_mask_bit_i |=> error_event_o == '0; endproperty
    a_gmask: assert property (p_gmask) else $error("event passed global mask");
    property p_no_gpi; 1'b1 |=> (error_event_o[7:0] & ~$past(input_error_i)) == 8'h00; endproperty
    a_no_gpi: assert property (p_no_gpi) else $error("input event invented");
    property p_no_fan; 1'b1 |=> (error_event_o[11:8] & ~$past(fan_error_i)) == 4'h0; endproperty
    a_no_fan: assert property (p_no_fan) else $error("fan event invented");
    property p_level; 1'b1 |=> input_level_o == $past(input_level_i); endproperty
    a_level: assert property (p_level) else $error("live level altered");
    property p_z1; zone1_temp_raw_valid_i |=> zone1_temp_valid_o; endproperty
    a_z1: assert property (p_z1) else $error("zone 1 result missing");
    property p_z2; !zone2_temp_raw_valid_i |=> !zone2_temp_valid_o; endproperty
    a_z2: assert property (p_z2) else $error("zone 2 result unasked");
    c_gmask: cover property (global_error_mask_bit_i && input_error_i != 8'h00);
    c_s1fan: cover property (sleep_state_field_o == 2'h1 && fan_error_i != 4'h0);
    c_zb2b: cover property (zone1_temp_raw_valid_i ##1 zone1_temp_valid_o);
endmodule // sleep_mask_props
`default_nettype wire

// ---- tb/mask_host_model.sv ----
// Host model issuing byte register writes and reads
`timescale 1ns/1ns
`default_nettype none
module mask_host_model (
    input  wire logic       clk_sys_i,
    output var logic [7:0]  reg_addr_o,
    output var logic [7:0]  reg_wdata_o,
    output var logic        reg_write_o,
    output var logic        reg_read_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i
);
    initial {reg_addr_o, reg_wdata_o, reg_write_o, reg_read_o} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_write_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_write_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_read_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_read_o <= 1'b0;
        @(negedge clk_sys_i);
        d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
    endtask
endmodule // mask_host_model
`default_nettype wire

// ---- tb/sleep_state_error_masking_tb.sv ----
// Self-checking bench for the sleep-state error mask bank
`timescale 1ns/1ns
`default_nettype none
`include "sleep_mask_cfg.svh"
module sleep_state_error_masking_tb;
    localparam logic [7:0] WM [12] = '{8'h03,8'hff,8'h0f,8'hff,8'h0f,8'h0f,8'hff,8'h0f,8'hff,8'h3f,8'h3f,8'h3f};
    localparam logic [7:0] RV [12] = '{8'h03,8'hff,8'h0f,8'hff,8'h0f,8'h07,8'hff,8'h07,8'hff,8'h3f,8'h00,8'h00};
    logic              clk_sys_i = 1'b0;
    logic              sys_rst_i = 1'b1;
    logic              gm = 1'b0, zv = 1'b0, rv, wr, rd, z1v, z2v;
    logic [7:0]        ierr = '0, lvl_i = '0, zraw = '0, addr, wdata, rdata, lvl_o, z1o, z2o;
    logic [3:0]        fan = '0;
    logic [2:0]        ana = '0;
    logic [1:0]        zt = '0, zd = '0, vh = '0, ts = '0, cv = '0, sf;
    logic [24:0]       ev_o;
    logic [7:0]        sh [12];
    int                n_fail = 0, compares = 0, cyc = 0, seed = 32'h5fa8;
    always #50 clk_sys_i = ~clk_sys_i;
    sleep_state_error_masking i_sleep_state_error_masking (
        .clk_sys_i, .sys_rst_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr),
        .reg_read_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rv), .global_error_mask_bit_i(gm),
        .input_error_i(ierr), .fan_error_i(fan), .analog_error_i(ana), .zone_temp_error_i(zt),
        .zone_diode_error_i(zd), .regulator_hot_input_i(vh), .termination_sense_input_i(ts),
        .core_volt_dynamic_error_i(cv), .input_level_i(lvl_i), .input_level_o(lvl_o),
        .error_event_o(ev_o), .sleep_state_field_o(sf), .zone1_temp_raw_i(zraw),
        .zone1_temp_raw_valid_i(zv), .zone2_temp_raw_i(zraw), .zone2_temp_raw_valid_i(zv),
        .zone1_temp_o(z1o), .zone1_temp_valid_o(z1v), .zone2_temp_o(z2o), .zone2_temp_valid_o(z2v));
    mask_host_model i_mask_host_model (.clk_sys_i, .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_write_o(wr), .reg_read_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rv));
    // -------
    // Helpers
    // -------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Standard per-state sets are zero at the default parameters
    function automatic logic [24:0] exp_ev(logic [24:0] e, logic g);
        logic [24:0] s;
        logic [3:0]  vt;
        s[7:0] = sh[8] | (sh[0] == 1 ? sh[1] : sh[0] == 2 ? sh[3] : sh[0] == 3 ? sh[6] : 8'h00);
        s[11:8] = sh[0] == 1 ? sh[2][3:0] : sh[0] == 2 ? sh[4][3:0] : 4'h0;
        vt = sh[0] == 2 ? sh[5][3:0] : sh[0] == 3 ? sh[7][3:0] : 4'h0;
        s[24:12] = {sh[9][5:0], {4{vt[3]}}, vt[2:0]};
        return g ? 25'h0 : e & ~s;
    endfunction
    function automatic logic [7:0] sat(logic [7:0] r, logic [5:0] o);
        int t;
        t = $signed(r) + $signed(o);
        return t > 127 ? 8'h7f : t < -128 ? 8'h80 : t[7:0];
    endfunction
    task automatic wreg(input int i, input logic [7:0] d);
        i_mask_host_model.wr(8'he4 + i[7:0], d);
        sh[i] = d & WM[i];
    endtask
    task automatic chk_regs();
        logic [7:0] d;
        for (int i = 0; i < 13; i++)
        begin
            i_mask_host_model.rd(i < 12 ? 8'he4 + i[7:0] : 8'hf0, d);
            chk(d, i < 12 ? sh[i] : 8'h00);
        end
    endtask
    task automatic do_reset();
        @(posedge clk_sys_i) sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        foreach (sh[i]) sh[i] = RV[i];
        @(negedge clk_sys_i);
        chk(sf, 2'h3);
        chk_regs();
    endtask
    task automatic ev_step(input logic [24:0] e, input logic g);
        logic [7:0] l;
        l = $random(seed);
        @(posedge clk_sys_i);
        {cv, ts, vh, zd, zt, ana, fan, ierr} <= e;
        gm <= g;
        lvl_i <= l;
        @(negedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(ev_o, exp_ev(e, g));
        chk(lvl_o, l);
    endtask
    task automatic temp_step(input logic [7:0] r, input logic [5:0] o1, input logic [5:0] o2);
        wreg(10, {2'b11, o1});
        wreg(11, {2'b11, o2});
        @(posedge clk_sys_i);
        zraw <= r;
        zv <= 1'b1;
        @(posedge clk_sys_i);
        zv <= 1'b0;
        @(negedge clk_sys_i);
        chk({z1v, z2v, z1o, z2o}, {2'b11, sat(r, o1), sat(r, o2)});
    endtask
    // Hang guard; a full run needs about a thousand cycles
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    // ---------
    // Scenarios
    // ---------
    initial
    begin
        logic [31:0] r;
        do_reset();
        $display("reset values done");
        for (int i = 0; i < 12; i++) wreg(i, 8'hff);
        i_mask_host_model.wr(8'hf0, 8'h5a);
        chk_regs();
        $display("reserved bits done");
        ev_step('1, 1'b1);
        ev_step('1, 1'b0);
        for (int k = 0; k < 300; k++)
        begin
            r = $random(seed);
            if (k % 8 == 0) wreg(0, {6'h00, k[4:3]});
            if (r[31:30] == 2'b00) wreg(r[3:0] % 12, r[15:8]);
            ev_step(25'($random(seed)), r[29:27] == 3'b000);
        end
        $display("masking done");
        temp_step(8'h7f, 6'h01, 6'h1f);
        temp_step(8'h80, 6'h20, 6'h3f);
        temp_step(8'h10, 6'h3f, 6'h20);
        for (int k = 0; k < 20; k++)
        begin
            r = $random(seed);
            temp_step(r[7:0], r[13:8], r[19:14]);
        end
        $display("zone offsets done");
        do_reset();
        $display("second reset done");
        end_of_test();
    end
endmodule // sleep_state_error_masking_tb
bind sleep_state_error_masking sleep_mask_props i_sleep_mask_props (.*);
`default_nettype wire
